// ==== src/sdc_top.sv ====
// Implementation choices: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
module sdc_top
   import sdc_pkg::*;
(
   input  wire logic        aclk,           // Register clock.
   input  wire logic        aresetn,        // Synchronous reset, active low.
   input  wire logic        mclk,           // Memory link clock.
   input  wire logic [7:0]  s_axi_awaddr,   // Write address.
   input  wire logic        s_axi_awvalid,  // Write address valid.
   output logic             s_axi_awready,  // Write address ready.
   input  wire logic [31:0] s_axi_wdata,    // Write data.
   input  wire logic [3:0]  s_axi_wstrb,    // Write strobes.
   input  wire logic        s_axi_wvalid,   // Write data valid.
   output logic             s_axi_wready,   // Write data ready.
   output logic [1:0]       s_axi_bresp,    // Write response.
   output logic             s_axi_bvalid,   // Write response valid.
   input  wire logic        s_axi_bready,   // Write response ready.
   input  wire logic [7:0]  s_axi_araddr,   // Read address.
   input  wire logic        s_axi_arvalid,  // Read address valid.
   output logic             s_axi_arready,  // Read address ready.
   output logic [31:0]      s_axi_rdata,    // Read data.
   output logic [1:0]       s_axi_rresp,    // Read response.
   output logic             s_axi_rvalid,   // Read data valid.
   input  wire logic        s_axi_rready,   // Read data ready.
   input  wire logic        chip_big_endian, // Chip endian setting, static.
   input  wire logic        mem_req,        // Access request on mclk.
   input  wire logic        mem_req_wr,     // Access is a write.
   input  wire logic [22:0] mem_req_addr,   // Access word address.
   output logic             mem_ack,        // Access taken, one mclk cycle.
   output logic [2:0]       mem_cmd,        // Memory command code.
   output logic [14:0]      mem_addr,       // Memory bank and address lines.
   output logic             memory_clock_out, // Gated memory clock.
   output logic             bus_clock_out,  // Gated external bus clock.
   output logic             wide_path,      // High for a 32-bit path.
   output logic             swap_bytes      // Byte lanes swapped.
);
   sdc_cfg_if cfg ();

   logic [15:0] memory_mode_word_ff;
   logic [11:0] init_time_ff;
   logic [11:0] rfc_ff;
   logic [3:0]  refresh_busy_cycles_ff;
   logic [18:0] timing_ff;
   logic [16:0] access_ff;
   logic        auto_refresh_enable_ff;
   logic        self_refresh_enable_ff;
   logic        unlocked_ff;
   logic        memory_clock_pin_stop_ff;
   logic        bus_clock_pin_stop_ff;
   logic        external_bus_enable_ff;
   logic        req_tgl_ff;
   logic [2:0]  done_sync_ff;
   logic        init_in_progress_flag_ff;
   logic [1:0]  mrst_ff;
   logic        aw_got_ff;
   logic        w_got_ff;
   logic [7:0]  awaddr_ff;
   logic [31:0] wdata_ff;
   logic [3:0]  wstrb_ff;
   logic        b_err_ff;
   logic        rd_err;
   logic [31:0] rd_mux;
   sdc_cmd_type eng_cmd;

   // Write channel: each half may arrive first; latch it and wait for the other.
   assign s_axi_awready = !aw_got_ff && !s_axi_bvalid;
   assign s_axi_wready  = !w_got_ff && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;
   assign s_axi_bresp   = b_err_ff ? 2'h2 : 2'h0;
   wire aw_now = aw_got_ff || (s_axi_awvalid && s_axi_awready);
   wire w_now  = w_got_ff || (s_axi_wvalid && s_axi_wready);
   wire [7:0]  wa  = aw_got_ff ? awaddr_ff : s_axi_awaddr;
   wire [31:0] wd  = w_got_ff ? wdata_ff : s_axi_wdata;
   wire [3:0]  ws  = w_got_ff ? wstrb_ff : s_axi_wstrb;
   wire        wr_fire = aw_now && w_now && !s_axi_bvalid;
   // Registers are whole-word; partial strobes are ignored rather than merged.
   wire        full = ws == 4'hf;
   wire        wr_go = wr_fire && full;
   wire        wr_known = wa inside {OFS_MODE_WORD, OFS_INIT_CTRL, OFS_INIT_TIME,
                          OFS_REFRESH, OFS_ACCESS, OFS_TIMING, OFS_KEY, OFS_CLK_CTRL,
                          OFS_SYS_CTRL, OFS_STATUS};

   // Keyed system control and clock-stop writes.
   wire key_wr   = wr_go && wa == OFS_KEY;
   wire clk_wr   = wr_go && wa == OFS_CLK_CTRL && unlocked_ff;
   wire sys_wr   = wr_go && wa == OFS_SYS_CTRL && wd[15:8] == KEY_SYSCTRL;
   wire init_wr  = wr_go && wa == OFS_INIT_CTRL;
   // Init is refused while either refresh mode is still on.
   wire init_go  = init_wr && wd[0] && !init_in_progress_flag_ff
                   && !auto_refresh_enable_ff && !self_refresh_enable_ff;
   wire done_evt = done_sync_ff[2] ^ done_sync_ff[1];

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_got_ff    <= 1'b0;
         w_got_ff     <= 1'b0;
         awaddr_ff    <= 8'h0;
         wdata_ff     <= 32'h0;
         wstrb_ff     <= 4'h0;
         s_axi_bvalid <= 1'b0;
         b_err_ff     <= 1'b0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) awaddr_ff <= s_axi_awaddr;
         if (s_axi_wvalid && s_axi_wready) wdata_ff <= s_axi_wdata;
         if (s_axi_wvalid && s_axi_wready) wstrb_ff <= s_axi_wstrb;
         aw_got_ff <= aw_now && !wr_fire;
         w_got_ff  <= w_now && !wr_fire;
         if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            b_err_ff     <= !wr_known;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Configuration registers.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         memory_mode_word_ff <= MODE_WORD_RST;
         init_time_ff <= INIT_TIME_RST;
         rfc_ff       <= RFC_RST;
         refresh_busy_cycles_ff      <= REFRESH_BUSY_CYCLES_RST;
         timing_ff    <= TIMING_RST;
         access_ff    <= ACCESS_RST;
         auto_refresh_enable_ff <= 1'b0;
         self_refresh_enable_ff <= 1'b0;
      end else if (wr_go) begin
         case (wa)
            // Reserved mode-word bits forced to zero.
            OFS_MODE_WORD: memory_mode_word_ff <= {6'h0, wd[9:0]};
            OFS_INIT_TIME: init_time_ff <= wd[11:0];
            OFS_REFRESH: begin
               rfc_ff  <= wd[11:0];
               refresh_busy_cycles_ff <= wd[19:16];
            end
            OFS_ACCESS: access_ff <= wd[16:0];
            OFS_TIMING: timing_ff <= wd[18:0];
            OFS_INIT_CTRL: begin
               auto_refresh_enable_ff <= wd[1];
               self_refresh_enable_ff <= wd[2];
            end
            default: ;
         endcase
      end
   end

   // Keys, clock stops and bus enable.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         unlocked_ff <= 1'b0;
         memory_clock_pin_stop_ff <= 1'b0;
         bus_clock_pin_stop_ff    <= 1'b0;
         external_bus_enable_ff   <= 1'b0;
      end else begin
         if (key_wr && wd[15:0] == KEY_UNLOCK) unlocked_ff <= 1'b1;
         else if (key_wr && wd[15:0] == KEY_LOCK) unlocked_ff <= 1'b0;
         if (clk_wr) begin
            memory_clock_pin_stop_ff <= wd[0];
            bus_clock_pin_stop_ff    <= wd[1];
         end
         if (sys_wr) external_bus_enable_ff <= wd[1];
      end
   end

   // Init handshake: toggle out, toggle back; done clears the busy flag.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         req_tgl_ff <= 1'b0;
         done_sync_ff <= 3'h0;
         init_in_progress_flag_ff <= 1'b0;
      end else begin
         done_sync_ff <= {done_sync_ff[1:0], cfg.init_done_tgl};
         if (init_go) begin
            req_tgl_ff <= ~req_tgl_ff;
            init_in_progress_flag_ff <= 1'b1;
         end else if (done_evt) begin
            init_in_progress_flag_ff <= 1'b0;
         end
      end
   end

   // Memory-domain reset synchroniser.
   always_ff @(posedge mclk) begin
      mrst_ff <= {mrst_ff[0], aresetn};
   end

   // Latency mismatch and active-period checks for software.
   wire cl_mismatch = timing_ff[2:0] != memory_mode_word_ff[6:4];
   wire ras_bad = {1'b0, timing_ff[18:16]}
                  > ({2'h0, timing_ff[9:8]} + {1'b0, timing_ff[2:0]});

   assign rd_err = !(s_axi_araddr inside {OFS_MODE_WORD, OFS_INIT_CTRL, OFS_INIT_TIME,
                     OFS_REFRESH, OFS_ACCESS, OFS_TIMING, OFS_KEY, OFS_CLK_CTRL,
                     OFS_SYS_CTRL, OFS_STATUS});
   always_comb begin
      case (s_axi_araddr)
         OFS_MODE_WORD: rd_mux = {16'h0, memory_mode_word_ff};
         OFS_INIT_CTRL: rd_mux = {29'h0, self_refresh_enable_ff,
                                  auto_refresh_enable_ff, 1'b0};
         OFS_INIT_TIME: rd_mux = {20'h0, init_time_ff};
         OFS_REFRESH:   rd_mux = {12'h0, refresh_busy_cycles_ff, 4'h0, rfc_ff};
         OFS_ACCESS:    rd_mux = {15'h0, access_ff};
         OFS_TIMING:    rd_mux = {13'h0, timing_ff};
         OFS_KEY:       rd_mux = {31'h0, unlocked_ff};
         OFS_CLK_CTRL:  rd_mux = {30'h0, bus_clock_pin_stop_ff, memory_clock_pin_stop_ff};
         OFS_SYS_CTRL:  rd_mux = {30'h0, external_bus_enable_ff, 1'b1};
         OFS_STATUS:    rd_mux = {29'h0, ras_bad, cl_mismatch, init_in_progress_flag_ff};
         default:       rd_mux = 32'h0;
      endcase
   end

   // Read channel: one-cycle answer held until rready.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0;
         s_axi_rresp  <= 2'h0;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= rd_mux;
         s_axi_rresp  <= rd_err ? 2'h2 : 2'h0;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // Configuration is quasi-static; software changes it only while idle.
   assign cfg.init_req_tgl    = req_tgl_ff;
   assign cfg.mode_word       = memory_mode_word_ff;
   assign cfg.init_time       = init_time_ff;
   assign cfg.refresh_interval_count             = rfc_ff;
   assign cfg.refresh_busy_cycles            = refresh_busy_cycles_ff;
   assign cfg.timing          = timing_ff;
   assign cfg.access_en       = access_ff[0] && external_bus_enable_ff;
   assign cfg.refresh_en      = auto_refresh_enable_ff;
   assign cfg.self_refresh_en = self_refresh_enable_ff;
   assign cfg.mux_sel         = access_ff[13:12];
   assign cfg.mem_stop        = memory_clock_pin_stop_ff;

   sdc_mem_engine u_eng (
      .mclk       (mclk),
      .mresetn    (mrst_ff[1]),
      .cfg        (cfg),
      .req        (mem_req),
      .req_wr     (mem_req_wr),
      .req_addr   (mem_req_addr),
      .ack        (mem_ack),
      .cmd        (eng_cmd),
      .maddr      (mem_addr),
      .clk_en_out (memory_clock_out)
   );
   assign mem_cmd       = eng_cmd;
   assign bus_clock_out = !bus_clock_pin_stop_ff;
   // Width 00b is the 16-bit path; any other code selects the wide path.
   assign wide_path     = access_ff[5:4] != WIDTH_16;
   // Byte order 0 follows the chip; 1 inverts it.
   assign swap_bytes    = chip_big_endian ^ access_ff[8];

   property p_init_busy;
      @(posedge aclk) disable iff (!aresetn)
      init_go |=> init_in_progress_flag_ff;
   endproperty
   a_init_busy: assert property (p_init_busy)
      else $error("Init flag not set after request.");

   property p_lock;
      @(posedge aclk) disable iff (!aresetn)
      (wr_go && wa == OFS_CLK_CTRL && !unlocked_ff) |=> $stable(memory_clock_pin_stop_ff);
   endproperty
   a_lock: assert property (p_lock)
      else $error("Locked clock control changed.");

   property p_sys_key;
      @(posedge aclk) disable iff (!aresetn)
      (wr_go && wa == OFS_SYS_CTRL && wd[15:8] != KEY_SYSCTRL)
         |=> $stable(external_bus_enable_ff);
   endproperty
   a_sys_key: assert property (p_sys_key)
      else $error("Unkeyed system control write took effect.");

   property p_rsv;
      @(posedge aclk) disable iff (!aresetn)
      memory_mode_word_ff[11:10] == 2'h0;
   endproperty
   a_rsv: assert property (p_rsv)
      else $error("Reserved mode bits nonzero.");

   property p_refresh_block;
      @(posedge aclk) disable iff (!aresetn)
      (init_wr && (auto_refresh_enable_ff || self_refresh_enable_ff))
         |=> $stable(req_tgl_ff);
   endproperty
   a_refresh_block: assert property (p_refresh_block)
      else $error("Init started with refresh enabled.");

   property p_clk_stop;
      @(posedge aclk) disable iff (!aresetn)
      bus_clock_pin_stop_ff |-> !bus_clock_out;
   endproperty
   a_clk_stop: assert property (p_clk_stop)
      else $error("Bus clock running while stopped.");

   property p_width;
      @(posedge aclk) disable iff (!aresetn)
      (access_ff[5:4] == WIDTH_16) |-> !wide_path;
   endproperty
   a_width: assert property (p_width)
      else $error("Width field 00b not a 16-bit path.");

   property p_endian;
      @(posedge aclk) disable iff (!aresetn)
      !access_ff[8] |-> swap_bytes == chip_big_endian;
   endproperty
   a_endian: assert property (p_endian)
      else $error("Byte order differs from chip setting.");
endmodule

// ==== src/sdc_pkg.sv ====
package sdc_pkg;
   // Register byte offsets on the AXI4-Lite bus.
   localparam logic [7:0] OFS_MODE_WORD = 8'h00;
   localparam logic [7:0] OFS_INIT_CTRL = 8'h04;
   localparam logic [7:0] OFS_INIT_TIME = 8'h08;
   localparam logic [7:0] OFS_REFRESH   = 8'h0c;
   localparam logic [7:0] OFS_ACCESS    = 8'h10;
   localparam logic [7:0] OFS_TIMING    = 8'h14;
   localparam logic [7:0] OFS_KEY       = 8'h18;
   localparam logic [7:0] OFS_CLK_CTRL  = 8'h1c;
   localparam logic [7:0] OFS_SYS_CTRL  = 8'h20;
   localparam logic [7:0] OFS_STATUS    = 8'h24;
   // Keys.
   localparam logic [15:0] KEY_UNLOCK  = 16'ha503;
   localparam logic [15:0] KEY_LOCK    = 16'ha500;
   localparam logic [7:0]  KEY_SYSCTRL = 8'h5a;
   // Mode word fields.
   localparam int MW_BL_LSB = 0;
   localparam int MW_BT_BIT = 3;
   localparam int MW_CL_LSB = 4;
   localparam int MW_OM_LSB = 7;
   localparam int MW_WB_BIT = 9;
   localparam int MW_RSV_LSB = 10;
   localparam logic [15:0] MODE_WORD_RST = 16'h0230;
   // Init timing fields: precharge 2:0, refresh count 7:4, interval 11:8.
   localparam logic [2:0] PRC_BASE = 3'h3;
   localparam logic [3:0] INIT_REFRESH_INTERVAL_BASE = 4'h3;
   localparam logic [11:0] INIT_TIME_RST = 12'h120;
   // Refresh: interval 11:0, busy cycles 19:16.
   localparam logic [11:0] RFC_RST  = 12'h3a9;
   localparam logic [3:0]  REFRESH_BUSY_CYCLES_RST = 4'h3;
   // Timing: cl 2:0, rp 6:4, rcd 9:8, wr 12, ras 18:16.
   localparam logic [18:0] TIMING_RST = 19'h21123;
   // Access register: enable 0, width 5:4, byte order 8, mux 13:12, continuous 16.
   localparam logic [16:0] ACCESS_RST = 17'h01000;
   localparam logic [1:0] MUX_SHIFT9 = 2'h1;
   localparam logic [1:0] WIDTH_16   = 2'h0;
   localparam int          ROW_SHIFT_BASE = 8;
   // Memory commands.
   typedef enum logic [2:0] {CMD_NOP, CMD_PRE, CMD_REF, CMD_MRS, CMD_ACT,
                             CMD_RD, CMD_WR} sdc_cmd_type;
endpackage

// ==== src/sdc_cfg_if.sv ====
`timescale 1ns/1ps
interface sdc_cfg_if;
   logic        init_req_tgl;
   logic        init_done_tgl;
   logic [15:0] mode_word;
   logic [11:0] init_time;
   logic [11:0] refresh_interval_count;
   logic [3:0]  refresh_busy_cycles;
   logic [18:0] timing;
   logic        access_en;
   logic        refresh_en;
   logic        self_refresh_en;
   logic [1:0]  mux_sel;
   logic        mem_stop;
   modport reg_side (output init_req_tgl, mode_word, init_time, refresh_interval_count, refresh_busy_cycles, timing,
                     access_en, refresh_en, self_refresh_en, mux_sel, mem_stop,
                     input init_done_tgl);
   modport mem_side (input init_req_tgl, mode_word, init_time, refresh_interval_count, refresh_busy_cycles, timing,
                     access_en, refresh_en, self_refresh_en, mux_sel, mem_stop,
                     output init_done_tgl);
endinterface

// ==== src/sdc_mem_engine.sv ====
`timescale 1ns/1ps
module sdc_mem_engine
   import sdc_pkg::*;
(
   input  wire logic    mclk,        // Memory link clock.
   input  wire logic    mresetn,     // Reset, already synchronised, active low.
   sdc_cfg_if.mem_side  cfg,         // Static configuration from the register side.
   input  wire logic    req,         // Access request, level.
   input  wire logic    req_wr,      // Access is a write.
   input  wire logic [22:0] req_addr, // Word address of the access.
   output logic         ack,         // Access command issued, one cycle.
   output sdc_cmd_type  cmd,         // Command to the memory.
   output logic [14:0]  maddr,       // Bank and address lines.
   output logic         clk_en_out   // Memory clock gate, high while running.
);
   typedef enum {S_IDLE, S_PRE, S_IREF, S_MRS, S_RUN, S_BUSY} sdc_state_type;
   sdc_state_type st_ff;
   logic [2:0]  rq_sync_ff;
   logic [1:0]  ms_sync_ff;
   logic [3:0]  irefs_ff;
   logic [11:0] wait_ff;
   logic [11:0] rcnt_ff;
   logic        done_ff;
   logic [11:0] shift_amt;
   wire         start_init = rq_sync_ff[2] ^ rq_sync_ff[1];
   wire         mode_ok = cfg.access_en;
   wire [11:0]  prc_wait = {9'h0, cfg.init_time[2:0]} + {9'h0, PRC_BASE} - 12'h1;
   wire [11:0]  init_refresh_interval_wait = {8'h0, cfg.init_time[11:8]} + {8'h0, INIT_REFRESH_INTERVAL_BASE} - 12'h1;
   wire [11:0]  refresh_busy_cycles_wait = {8'h0, cfg.refresh_busy_cycles};
   wire         refresh_due = cfg.refresh_en && rcnt_ff == 12'h0;
   // Row is ORed onto the column from bit ROW_SHIFT_BASE plus the mux field, less 9.
   assign shift_amt = 12'(ROW_SHIFT_BASE) + {10'h0, cfg.mux_sel};
   assign cfg.init_done_tgl = done_ff;
   assign clk_en_out = ~ms_sync_ff[1];

   // Toggle crossing for the init request, level sync for clock stop.
   always_ff @(posedge mclk) begin
      if (!mresetn) begin
         rq_sync_ff <= 3'h0;
         ms_sync_ff <= 2'h0;
      end else begin
         rq_sync_ff <= {rq_sync_ff[1:0], cfg.init_req_tgl};
         ms_sync_ff <= {ms_sync_ff[0], cfg.mem_stop};
      end
   end

   // Refresh interval counter holds at zero when it expires and reloads once the sequencer is in S_BUSY.
   always_ff @(posedge mclk) begin
      if (!mresetn || !cfg.refresh_en)
         rcnt_ff <= cfg.refresh_interval_count;
      else if (rcnt_ff == 12'h0 && st_ff == S_BUSY)
         rcnt_ff <= cfg.refresh_interval_count;
      else if (rcnt_ff != 12'h0)
         rcnt_ff <= rcnt_ff - 12'h1;
   end

   // Sequencer: init, then refresh arbitration over accesses.
   always_ff @(posedge mclk) begin
      if (!mresetn) begin
         st_ff    <= S_IDLE;
         cmd      <= CMD_NOP;
         maddr    <= 15'h0;
         ack      <= 1'b0;
         irefs_ff <= 4'h0;
         wait_ff  <= 12'h0;
         done_ff  <= 1'b0;
      end else begin
         cmd <= CMD_NOP;
         ack <= 1'b0;
         if (wait_ff != 12'h0)
            wait_ff <= wait_ff - 12'h1;
         case (st_ff)
            S_IDLE, S_RUN: begin
               if (start_init) begin
                  cmd     <= CMD_PRE;
                  wait_ff <= prc_wait;
                  irefs_ff <= cfg.init_time[7:4];
                  st_ff   <= S_PRE;
               end else if (st_ff == S_RUN && refresh_due && mode_ok) begin
                  cmd     <= CMD_REF;
                  wait_ff <= refresh_busy_cycles_wait;
                  st_ff   <= S_BUSY;
               end else if (st_ff == S_RUN && req && mode_ok) begin
                  cmd   <= req_wr ? CMD_WR : CMD_RD;
                  maddr <= 15'(req_addr[8:0]) | 15'(req_addr[22:9] << (shift_amt - 12'd9));
                  ack   <= 1'b1;
               end
            end
            S_PRE, S_IREF: begin
               if (wait_ff == 12'h0) begin
                  if (irefs_ff != 4'h0) begin
                     cmd      <= CMD_REF;
                     irefs_ff <= irefs_ff - 4'h1;
                     wait_ff  <= init_refresh_interval_wait;
                     st_ff    <= S_IREF;
                  end else begin
                     // Mode word loaded from the register, never from an access.
                     cmd   <= CMD_MRS;
                     maddr <= {3'h0, cfg.mode_word[11:0]};
                     st_ff <= S_MRS;
                  end
               end
            end
            S_MRS: begin
               done_ff <= ~done_ff;
               st_ff   <= S_RUN;
            end
            S_BUSY: begin
               if (wait_ff == 12'h0)
                  st_ff <= S_RUN;
            end
            default: st_ff <= S_IDLE;
         endcase
      end
   end

   // After a refresh the memory stays busy; no read or write may follow in that time.
   property p_busy_holds;
      @(posedge mclk) disable iff (!mresetn)
      (cmd == CMD_REF && st_ff == S_BUSY) |=> (!(cmd inside {CMD_RD, CMD_WR}))[*4];
   endproperty
   a_busy_holds: assert property (p_busy_holds)
      else $error("Access issued during refresh busy time.");
endmodule

// ==== test/sdc_mem_model.sv ====
`timescale 1ns/1ps
// The memory only listens here, so the stand-in tallies what it is sent.
module sdc_mem_model (
   input wire logic        mclk, // Memory clock.
   input wire logic [2:0]  cmd,  // Command code.
   input wire logic [14:0] addr, // Address lines.
   input wire logic        ack   // Access taken.
);
   int          n_ref = 0;
   int          n_acc = 0;
   logic [14:0] mode_seen = 15'h0;
   // Counts refreshes and accesses, keeps the last mode word loaded.
   always @(posedge mclk) begin
      n_ref <= n_ref + int'(cmd === 3'h2);
      n_acc <= n_acc + int'(ack === 1'b1);
      if (cmd === 3'h3) mode_seen <= addr;
   end
endmodule

// ==== test/sdc_top_test.sv ====
`timescale 1ns/1ps
module sdc_top_test;
   import sdc_pkg::*;
   logic aclk = 0, mclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
   logic arvalid = 0, rready = 0, req = 0, awr, wr_r, bv, arr, rv, ack, mco, bco, wp, sb;
   logic [7:0] awaddr = 0, araddr = 0;
   logic [31:0] wdata = 0, rdata, seed = 32'h476d, d, a_prev = 0;
   logic [1:0] bresp, rresp;
   logic [2:0] cmd;
   logic [14:0] maddr;
   int n_mismatch = 0, samples_checked = 0, cyc = 0, i;
   int rst_tab[4][2] = '{'{0, 32'h230}, '{12, 32'h303a9}, '{20, 32'h21123}, '{16, 32'h1000}};
   sdc_top dut (.aclk(aclk), .aresetn(aresetn), .mclk(mclk), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awr), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wr_r), .s_axi_bresp(bresp),
      .s_axi_bvalid(bv), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arr), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rready),
      .chip_big_endian(1'b0), .mem_req(req), .mem_req_wr(seed[23]),
      .mem_req_addr(seed[22:0]),
      .mem_ack(ack), .mem_cmd(cmd), .mem_addr(maddr), .memory_clock_out(mco),
      .bus_clock_out(bco), .wide_path(wp), .swap_bytes(sb));
   sdc_mem_model mem (.mclk(mclk), .cmd(cmd), .addr(maddr), .ack(ack));
   initial forever #50 aclk = ~aclk;
   initial forever #15 mclk = ~mclk;
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] t;
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction
   // The acked access used the address that stood one edge earlier; check it, then move on.
   always @(posedge mclk) begin
      a_prev <= seed;
      if (ack) begin
         chk({17'h0, maddr}, a_prev[8:0] | a_prev[22:9]);
         seed <= xs(seed);
      end
   end
   task automatic chk(input logic [31:0] got, exp);
      samples_checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Each channel is released only at the edge that takes it.
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      logic ta, tw, tb;
      awaddr <= a; wdata <= v; awvalid <= 1; wvalid <= 1; bready <= 1;
      do begin
         @(posedge aclk);
         ta = awvalid && awr;
         tw = wvalid && wr_r;
         tb = bv && bready;
         if (ta) awvalid <= 0;
         if (tw) wvalid <= 0;
      end while (!tb);
      bready <= 0;
      @(posedge aclk);
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      logic ta, tr;
      araddr <= a; arvalid <= 1; rready <= 1;
      do begin
         @(posedge aclk);
         ta = arvalid && arr;
         tr = rv && rready;
         v = {rdata[31:2], rdata[1:0] | rresp};
         if (ta) arvalid <= 0;
      end while (!tr);
      rready <= 0;
      @(posedge aclk);
   endtask
   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // The whole run needs some 500 cycles; a hang is cut off well after that.
   always @(posedge aclk) begin
      cyc++;
      if (cyc == 4000) begin
         n_mismatch++;
         give_verdict();
      end
   end
   initial begin
      repeat (2) @(posedge aclk);
      aresetn <= 1; req <= 1;
      @(posedge aclk);
      for (i = 0; i < 4; i++) begin
         rd(rst_tab[i][0], d);
         chk(d, rst_tab[i][1]);
      end
      chk({wp, sb}, 2'b00);
      rd(8'h40, d);
      chk(d[1:0], 2'h2);
      $display("reset values done");
      wr(8'h1c, 3); rd(8'h1c, d);
      chk(d[1:0], 0);
      wr(8'h18, 32'ha503); wr(8'h1c, 3); repeat (6) @(posedge aclk);
      chk({mco, bco}, 0);
      wr(8'h1c, 0); wr(8'h18, 32'ha500); repeat (6) @(posedge aclk);
      chk({mco, bco}, 3);
      wr(8'h1c, 3); rd(8'h18, d);
      chk(d[0], 0);
      wr(8'h20, 3); rd(8'h20, d);
      chk(d[1], 0);
      wr(8'h20, 32'h5a03); rd(8'h20, d);
      chk(d[1], 1);
      $display("keys done");
      wr(8'h04, 1); rd(8'h24, d);
      chk(d[0], 1);
      do rd(8'h24, d); while (d[0] !== 1'b0);
      chk(mem.n_ref, 2);
      chk(mem.mode_seen, 15'h230);
      chk(mem.n_acc, 0);
      $display("init done");
      wr(8'h10, 32'h1001); wr(8'h04, 2); repeat (400) @(posedge aclk);
      chk(mem.n_acc > 0, 1);
      chk(mem.n_ref > 2, 1);
      wr(8'h04, 3); rd(8'h24, d);
      chk(d[0], 0);
      $display("access done");
      give_verdict();
   end
endmodule
